/* File: hdl/contention_params.svh */
// Constants for the display memory contention controller.
// Assumes inclusion by bare name from design files.
`ifndef CONTENTION_PARAMS_SVH
`define CONTENTION_PARAMS_SVH
`define ADDR_W 14
`define UPD_ADDR_RST 14'h0000
`define STROBE_CYCLES 1
`endif

/* File: hdl/contention_pkg.sv */
// Types for the display memory contention controller.
// Assumes nothing beyond the params header.
package contention_pkg;
  typedef enum logic [2:0] {
    MODE_PRIORITY,
    MODE_INTERLEAVE,
    MODE_VBLANK,
    MODE_TRANSP_BLANK,
    MODE_TRANSP_INTERLEAVE
  } mode_e;
  typedef enum logic [1:0] {
    UPD_IDLE,
    UPD_WAIT_BLANK,
    UPD_STROBE
  } upd_state_e;
endpackage : contention_pkg

/* File: hdl/addr_select_if.sv */
// Interface carrying the address selection between the top and its selector.
// Assumes one clock domain.
`timescale 1ns/1ns
`default_nettype none
`include "contention_params.svh"
interface addr_select_if;
  logic [`ADDR_W-1:0] scan_addr;
  logic [`ADDR_W-1:0] host_addr;
  logic [`ADDR_W-1:0] upd_addr;
  logic use_host;
  logic use_upd;
  logic [`ADDR_W-1:0] sel_addr;
  modport top (output scan_addr, host_addr, upd_addr, use_host, use_upd, input sel_addr);
  modport sel (input scan_addr, host_addr, upd_addr, use_host, use_upd, output sel_addr);
endinterface : addr_select_if
`default_nettype wire

/* File: hdl/addr_selector.sv */
// Address multiplexer: scan address by default, host or update address on request.
// Assumes use_host and use_upd are never both set.
`timescale 1ns/1ns
`default_nettype none
module addr_selector (
  addr_select_if.sel sel
);
  always_comb
  begin
    if (sel.use_upd)
      sel.sel_addr = sel.upd_addr;
    else if (sel.use_host)
      sel.sel_addr = sel.host_addr;
    else
      sel.sel_addr = sel.scan_addr;
  end
endmodule : addr_selector
`default_nettype wire

/* File: hdl/display_memory_update_contention.sv */
// Display memory contention controller: drives the refresh address bus under five schemes.
// Assumes sys_clk is the character clock, synchronous with the host two-phase clock.
// Overview of operation
// RULE_01 - In priority mode the scan address goes to memory unless a host memory select is active.
// RULE_02 - The host presents address in phase one and moves data only in phase two.
// RULE_03 - In interleave mode phase one carries the scan address and phase two the host address.
// RULE_04 - The character clock equals or is an even multiple of the host clock in interleave.
// RULE_05 - A readable status bit shows vertical blanking, retrace plus margin lines.
// RULE_06 - In vertical blanking mode the host only accesses memory while blanking shows; the code grants mem_select without checking vblank.
// RULE_07 - For a blanking update the host loads the address first, then the data latch.
// RULE_08 - At the next horizontal or vertical blank the update address is driven and strobed.
// RULE_09 - A ready bit is set once the pending blanking update is done.
// RULE_10 - The update address increments after each completed update.
// RULE_11 - The host waits for ready before loading the next update.
// RULE_12 - In transparent interleave phase one carries scan and phase two the update address.
// RULE_13 - The host loads the update address before direct access in transparent interleave.
// RULE_14 - The refresh address bus is fourteen bits wide.
// RULE_15 - In interleave each display memory select increments the update address.
// RULE_16 - Writing a new update address clears ready until its strobe has been issued.
`timescale 1ns/1ns
`default_nettype none
`include "contention_params.svh"
module display_memory_update_contention #(
  parameter int ADDR_W = `ADDR_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Mode and timing
  input wire contention_pkg::mode_e mode,
  input wire logic phase2,
  input wire logic hblank,
  input wire logic vblank,
  input wire logic [ADDR_W-1:0] scan_addr,
  // Host side
  input wire logic [ADDR_W-1:0] host_addr,
  input wire logic mem_select,
  input wire logic upd_addr_wr,
  input wire logic [ADDR_W-1:0] upd_addr_data,
  // Memory side
  output logic [ADDR_W-1:0] refresh_address_bus,
  output logic update_store_strobe,
  output logic host_bus_gate,
  // Status
  output logic vblank_status,
  output logic update_ready
);
  addr_select_if asel ();
  addr_selector u_sel (
    .sel(asel)
  );
  contention_pkg::upd_state_e state_r, state_nxt;
  logic [ADDR_W-1:0] upd_addr_r, upd_addr_nxt;
  logic ready_r, ready_nxt;
  logic [ADDR_W-1:0] bus_r, bus_nxt;
  logic strobe_r, strobe_nxt;
  logic gate_r, gate_nxt;
  logic vbs_r, vbs_nxt;
  logic blank;
  logic interleave;
  assign blank = hblank | vblank;
  assign interleave = (mode == contention_pkg::MODE_INTERLEAVE) ||
                      (mode == contention_pkg::MODE_TRANSP_INTERLEAVE);
  // Selector steering
  assign asel.scan_addr = scan_addr;
  assign asel.host_addr = host_addr;
  assign asel.upd_addr = upd_addr_r;
  always_comb
  begin
    asel.use_host = 1'b0;
    asel.use_upd = 1'b0;
    unique case (mode)
      contention_pkg::MODE_PRIORITY, contention_pkg::MODE_VBLANK:
        asel.use_host = mem_select; // RULE_01
      contention_pkg::MODE_INTERLEAVE:
        asel.use_host = phase2; // RULE_03 RULE_04
      contention_pkg::MODE_TRANSP_INTERLEAVE:
        asel.use_upd = phase2; // RULE_12
      contention_pkg::MODE_TRANSP_BLANK:
        asel.use_upd = (state_r == contention_pkg::UPD_STROBE); // RULE_08
      default:
      begin
        asel.use_host = 1'b0;
        asel.use_upd = 1'b0;
      end
    endcase
  end
  // Update sequencer and outputs
  always_comb
  begin
    state_nxt = state_r;
    upd_addr_nxt = upd_addr_r;
    ready_nxt = ready_r;
    strobe_nxt = 1'b0;
    bus_nxt = asel.sel_addr;
    gate_nxt = asel.use_host;
    vbs_nxt = vblank; // RULE_05
    unique case (state_r)
      contention_pkg::UPD_IDLE:
        if (upd_addr_wr && mode == contention_pkg::MODE_TRANSP_BLANK)
          state_nxt = contention_pkg::UPD_WAIT_BLANK;
      contention_pkg::UPD_WAIT_BLANK:
        if (blank)
          state_nxt = contention_pkg::UPD_STROBE; // RULE_08
      contention_pkg::UPD_STROBE:
      begin
        strobe_nxt = 1'b1; // RULE_08
        upd_addr_nxt = upd_addr_r + 1'b1; // RULE_10
        ready_nxt = 1'b1; // RULE_09
        state_nxt = contention_pkg::UPD_IDLE;
      end
      default:
        state_nxt = contention_pkg::UPD_IDLE;
    endcase
    if (interleave && phase2 && mem_select)
      upd_addr_nxt = upd_addr_r + 1'b1; // RULE_15
    if (upd_addr_wr)
    begin
      upd_addr_nxt = upd_addr_data;
      ready_nxt = 1'b0; // RULE_16
      if (mode == contention_pkg::MODE_TRANSP_BLANK)
        state_nxt = contention_pkg::UPD_WAIT_BLANK;
    end
  end
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= contention_pkg::UPD_IDLE;
      upd_addr_r <= `UPD_ADDR_RST;
      ready_r <= 1'b1;
      bus_r <= '0;
      strobe_r <= 1'b0;
      gate_r <= 1'b0;
      vbs_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      upd_addr_r <= upd_addr_nxt;
      ready_r <= ready_nxt;
      bus_r <= bus_nxt;
      strobe_r <= strobe_nxt;
      gate_r <= gate_nxt;
      vbs_r <= vbs_nxt;
    end
  end
  assign refresh_address_bus = bus_r; // RULE_14
  assign update_store_strobe = strobe_r;
  assign host_bus_gate = gate_r;
  assign vblank_status = vbs_r;
  assign update_ready = ready_r;

  // Assertions
  a_strobe_sets_ready: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(update_store_strobe) |-> update_ready) // RULE_09
    else $error("ready not set with update strobe");
  a_strobe_addr_inc: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_r == contention_pkg::UPD_STROBE && !upd_addr_wr) |=> // RULE_10
    upd_addr_r == $past(upd_addr_r) + 1'b1)
    else $error("update address did not increment");
  a_strobe_on_bus: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_r == contention_pkg::UPD_STROBE && mode == contention_pkg::MODE_TRANSP_BLANK)
    |=> update_store_strobe && refresh_address_bus == $past(upd_addr_r)) // RULE_08
    else $error("strobe without update address on bus");
  a_wait_for_blank: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_r == contention_pkg::UPD_WAIT_BLANK && !blank && !upd_addr_wr)
    |=> state_r == contention_pkg::UPD_WAIT_BLANK) // RULE_08
    else $error("update left wait outside blanking");
  a_addr_wr_clears: assert property (@(posedge sys_clk) disable iff (!rstn)
    upd_addr_wr |=> !update_ready) // RULE_16
    else $error("ready not cleared by address write");
  a_vblank_status: assert property (@(posedge sys_clk) disable iff (!rstn)
    1'b1 |=> vblank_status == $past(vblank)) // RULE_05
    else $error("vertical blank status wrong");
  a_priority_sel: assert property (@(posedge sys_clk) disable iff (!rstn)
    (mode == contention_pkg::MODE_PRIORITY && mem_select) |=>
    refresh_address_bus == $past(host_addr) && host_bus_gate) // RULE_01
    else $error("host not selected on memory select");
  a_interleave_ph: assert property (@(posedge sys_clk) disable iff (!rstn)
    (mode == contention_pkg::MODE_TRANSP_INTERLEAVE && !phase2) |=>
    refresh_address_bus == $past(scan_addr)) // RULE_12
    else $error("scan address missing in phase one");
  a_upd_phase2: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_12
    (mode == contention_pkg::MODE_TRANSP_INTERLEAVE && phase2 && !upd_addr_wr) |=>
    refresh_address_bus == $past(upd_addr_r))
    else $error("update address missing in phase two");
  a_il_select_inc: assert property (@(posedge sys_clk) disable iff (!rstn)
    (interleave && phase2 && mem_select && !upd_addr_wr) |=>
    upd_addr_r == $past(upd_addr_r) + 1'b1) // RULE_15
    else $error("select did not increment update address");
  a_host_phase2: assert property (@(posedge sys_clk) disable iff (!rstn)
    (mode == contention_pkg::MODE_INTERLEAVE && phase2) |=>
    refresh_address_bus == $past(host_addr)) // RULE_03
    else $error("host address missing in phase two");
  c_blank_update: cover property (@(posedge sys_clk) disable iff (!rstn)
    upd_addr_wr ##[1:20] update_store_strobe);
  c_il_access: cover property (@(posedge sys_clk) disable iff (!rstn)
    mode == contention_pkg::MODE_TRANSP_INTERLEAVE && phase2 && mem_select);
  c_priority: cover property (@(posedge sys_clk) disable iff (!rstn)
    mode == contention_pkg::MODE_PRIORITY && mem_select);
endmodule : display_memory_update_contention
`default_nettype wire

/* File: bench/display_ram_model.sv */
// Display RAM behind an external holding latch; stores on the update strobe.
// Assumes the host loads the latch before the strobe.
`timescale 1ns/1ns
`default_nettype none
module display_ram_model (
  // Clock
  input wire logic sys_clk,
  // Memory side
  input wire logic [13:0] addr,
  input wire logic store,
  input wire logic [7:0] latch_data,
  // Readback
  input wire logic [13:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [0:16383];
  always_ff @(posedge sys_clk)
  begin
    if (store)
    begin
      mem[addr] <= latch_data;
    end
  end
  assign rd_data = mem[rd_addr];
endmodule : display_ram_model
`default_nettype wire

/* File: bench/display_memory_update_contention_bench.sv */
// Self-checking bench for the display memory contention controller.
// Assumes the design, its package and the RAM model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module display_memory_update_contention_bench;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  contention_pkg::mode_e mode = contention_pkg::MODE_PRIORITY;
  logic phase2 = 1'b0;
  logic hblank = 1'b0;
  logic vblank = 1'b0;
  logic [13:0] scan_addr = 14'h0123;
  logic [13:0] host_addr = 14'h2abc;
  logic mem_select = 1'b0;
  logic upd_addr_wr = 1'b0;
  logic [13:0] upd_addr_data = 14'h0000;
  logic [7:0] latch_data = 8'h00;
  logic [13:0] rd_addr = 14'h0000;
  logic [13:0] bus;
  logic strobe, gate, vb_status, ready;
  logic [7:0] rd_data;
  int n_mismatch = 0;
  int compares = 0;
  always #10 sys_clk = ~sys_clk;
  display_memory_update_contention uut (.sys_clk(sys_clk), .rstn(rstn), .mode(mode),
    .phase2(phase2), .hblank(hblank), .vblank(vblank), .scan_addr(scan_addr),
    .host_addr(host_addr), .mem_select(mem_select), .upd_addr_wr(upd_addr_wr),
    .upd_addr_data(upd_addr_data), .refresh_address_bus(bus), .update_store_strobe(strobe),
    .host_bus_gate(gate), .vblank_status(vb_status), .update_ready(ready));
  display_ram_model ram (.sys_clk(sys_clk), .addr(bus), .store(strobe),
    .latch_data(latch_data), .rd_addr(rd_addr), .rd_data(rd_data));
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic close_out;
    $display("counts compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  // Priority routing, plain and in vertical blanking mode
  task automatic test_priority(input contention_pkg::mode_e m);
    mode = m;
    vblank = 1'b1;
    mem_select = 1'b1;
    step(1);
    check("host bus", 16'(bus), 16'(host_addr));
    check("gate on", 16'(gate), 16'h0001);
    check("vblank on", 16'(vb_status), 16'h0001);
    mem_select = 1'b0;
    vblank = 1'b0;
    step(1);
    check("scan bus", 16'(bus), 16'(scan_addr));
    check("gate off", 16'(gate), 16'h0000);
    check("vblank off", 16'(vb_status), 16'h0000);
    $display("test priority done");
  endtask : test_priority
  task automatic test_interleave;
    mode = contention_pkg::MODE_INTERLEAVE;
    mem_select = 1'b1;
    step(1);
    check("phase one", 16'(bus), 16'(scan_addr));
    phase2 = 1'b1;
    step(1);
    check("phase two", 16'(bus), 16'(host_addr));
    phase2 = 1'b0;
    mem_select = 1'b0;
    $display("test interleave done");
  endtask : test_interleave
  // Load address, latch data, then wait for the chosen blanking interval
  task automatic blank_update(input logic use_h, input logic [13:0] ua, input logic [7:0] d);
    int i;
    check("ready before load", 16'(ready), 16'h0001);
    mode = contention_pkg::MODE_TRANSP_BLANK;
    upd_addr_data = ua;
    upd_addr_wr = 1'b1;
    step(1);
    upd_addr_wr = 1'b0;
    latch_data = d;
    step(3);
    check("ready clear", 16'(ready), 16'h0000);
    check("no early strobe", 16'(strobe), 16'h0000);
    hblank = use_h;
    vblank = !use_h;
    for (i = 0; i < 4 && strobe !== 1'b1; i++)
      step(1);
    check("update addr", 16'(bus), 16'(ua));
    check("ready set", 16'(ready), 16'h0001);
    hblank = 1'b0;
    vblank = 1'b0;
    rd_addr = ua;
    step(1);
    check("strobe end", 16'(strobe), 16'h0000);
    check("stored data", 16'(rd_data), 16'(d));
    $display("test blank update done");
  endtask : blank_update
  task automatic test_transp_interleave;
    mode = contention_pkg::MODE_TRANSP_INTERLEAVE;
    step(1);
    check("scan phase", 16'(bus), 16'(scan_addr));
    phase2 = 1'b1;
    mem_select = 1'b1;
    step(1);
    check("wrapped addr", 16'(bus), 16'h0000);
    mem_select = 1'b0;
    phase2 = 1'b0;
    upd_addr_data = 14'h0100;
    upd_addr_wr = 1'b1;
    step(1);
    check("scan after load", 16'(bus), 16'(scan_addr));
    upd_addr_wr = 1'b0;
    phase2 = 1'b1;
    mem_select = 1'b1;
    step(1);
    check("loaded addr", 16'(bus), 16'h0100);
    mem_select = 1'b0;
    phase2 = 1'b0;
    step(1);
    phase2 = 1'b1;
    step(1);
    check("select incr", 16'(bus), 16'h0101);
    phase2 = 1'b0;
    $display("test transparent interleave done");
  endtask : test_transp_interleave
  initial
  begin
    #20000;
    n_mismatch++;
    close_out();
  end
  initial
  begin
    step(12);
    check("reset ready", 16'(ready), 16'h0001);
    rstn = 1'b1;
    test_priority(contention_pkg::MODE_PRIORITY);
    test_priority(contention_pkg::MODE_VBLANK);
    test_interleave();
    blank_update(1'b1, 14'h1234, 8'h5a);
    blank_update(1'b0, 14'h3fff, 8'ha5);
    test_transp_interleave();
    close_out();
  end
endmodule : display_memory_update_contention_bench
`default_nettype wire
